// *** hdl/epctl_host.sv ***
// Host controller driving an 8K x 8 UV EPROM through its pins
`timescale 1ns/1ps
module epctl_host
  import epctl_pkg::*;
#(
  parameter int PULSE_CYC = EPCTL_PULSE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // User command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [12:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_fail,
  // EPROM pins
  output logic [12:0] addr_lines,
  output logic sel_n,
  output logic gate_n,
  output logic prog_n,
  output logic pp_high,
  output logic id_mode_voltage,
  output logic [7:0] data_lines_o,
  output logic data_lines_oe_n,
  input wire logic [7:0] data_lines_i
);
  // Complete controller state
  typedef struct packed {
    epctl_state_e st;
    logic [EPCTL_CNT_W-1:0] cnt;
    logic [4:0] tries;
    logic [6:0] over;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic ready;
    logic rvalid;
    logic [7:0] rdata;
    logic fail;
    logic sel_n;
    logic gate_n;
    logic prog_n;
    logic pp_high;
    logic idv;
    logic oe_n;
  } epctl_regs_s;
  epctl_regs_s r_q, r_d;
  logic [7:0] din_s; // Synchronised data lines
  logic over_phase; // Doing overprogram pulse
  // Data lines come from the device, synchronise first
  epctl_sync #(.W(8)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(data_lines_i),
    .dout(din_s)
  );
  assign over_phase = (r_q.over != 7'h00);
  // Next-state logic
  always_comb begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    unique case (r_q.st)
      EPCTL_ST_IDLE: begin
        r_d.ready = 1'b1;
        if (cmd_valid && r_q.ready) begin
          r_d.ready = 1'b0;
          r_d.addr = cmd_addr;
          r_d.wdata = cmd_wdata;
          r_d.tries = 5'h00;
          r_d.over = 7'h00;
          r_d.fail = 1'b0;
          r_d.cnt = '0;
          if (cmd_op == EPCTL_CMD_PROG) begin
            // Supply high and data driven, gate high
            r_d.pp_high = 1'b1;
            r_d.sel_n = 1'b0;
            r_d.gate_n = 1'b1;
            r_d.oe_n = 1'b0;
            r_d.st = EPCTL_ST_PSETUP;
          end else begin
            // Select first, gate stays high; id pin when asked
            r_d.idv = (cmd_op == EPCTL_CMD_ID);
            r_d.sel_n = 1'b0;
            r_d.st = EPCTL_ST_RSEL;
          end
        end
      end
      EPCTL_ST_RSEL: begin
        // Wait address access minus gate access before gate
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt >= EPCTL_CNT_W'(EPCTL_ADDR_ACC_CYC - EPCTL_GATE_ACC_CYC)) begin
          r_d.gate_n = 1'b0;
          r_d.cnt = '0;
          r_d.st = EPCTL_ST_RGATE;
        end
      end
      EPCTL_ST_RGATE: begin
        r_d.cnt = r_q.cnt + 1'b1;
        // Sample after gate access plus sync latency
        if (r_q.cnt >= EPCTL_CNT_W'(EPCTL_GATE_ACC_CYC + 2)) begin
          r_d.rdata = din_s;
          r_d.gate_n = 1'b1;
          r_d.sel_n = 1'b1;
          r_d.idv = 1'b0;
          r_d.cnt = '0;
          r_d.st = EPCTL_ST_RFLOAT;
        end
      end
      EPCTL_ST_RFLOAT: begin
        // Let device outputs float before next access
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt >= EPCTL_CNT_W'(EPCTL_FLOAT_CYC)) begin
          r_d.rvalid = 1'b1;
          r_d.st = EPCTL_ST_IDLE;
        end
      end
      EPCTL_ST_PSETUP: begin
        // Address, data, supply setup before strobe
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt >= EPCTL_CNT_W'(EPCTL_SETUP_CYC)) begin
          r_d.prog_n = 1'b0;
          r_d.cnt = '0;
          r_d.st = EPCTL_ST_PPULSE;
        end
      end
      EPCTL_ST_PPULSE: begin
        // One pulse, or the overprogram multiple of pulses
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt >= EPCTL_CNT_W'(PULSE_CYC - 1)) begin
          r_d.cnt = '0;
          if (over_phase && r_q.over > 7'h01) begin
            r_d.over = r_q.over - 7'h01;
          end else begin
            r_d.prog_n = 1'b1;
            r_d.st = EPCTL_ST_PHOLD;
          end
        end
      end
      EPCTL_ST_PHOLD: begin
        // Data hold after strobe, then release data for verify
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt >= EPCTL_CNT_W'(EPCTL_SETUP_CYC)) begin
          r_d.oe_n = 1'b1;
          r_d.cnt = '0;
          if (over_phase) begin
            r_d.over = 7'h00;
            r_d.st = EPCTL_ST_PDONE;
          end else begin
            r_d.tries = r_q.tries + 5'h01;
            r_d.st = EPCTL_ST_VGATE;
          end
        end
      end
      EPCTL_ST_VGATE: begin
        // Verify: supply high, gate low, strobe high
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt == EPCTL_CNT_W'(EPCTL_SETUP_CYC)) begin
          r_d.gate_n = 1'b0;
        end
        if (r_q.cnt >= EPCTL_CNT_W'(EPCTL_SETUP_CYC + EPCTL_GATE_ACC_CYC + 2)) begin
          r_d.rdata = din_s;
          r_d.gate_n = 1'b1;
          r_d.cnt = '0;
          r_d.st = EPCTL_ST_VFLOAT;
        end
      end
      EPCTL_ST_VFLOAT: begin
        // Wait for float, then decide: done, retry or fail
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt >= EPCTL_CNT_W'(EPCTL_FLOAT_CYC)) begin
          r_d.cnt = '0;
          if (r_q.rdata == r_q.wdata) begin
            // Byte verified: overprogram with tries x multiplier
            r_d.over = 7'(r_q.tries * EPCTL_OVER_MULT);
            r_d.oe_n = 1'b0;
            r_d.st = EPCTL_ST_PSETUP;
          end else if (((~r_q.rdata) & r_q.wdata) != 8'h00 || r_q.tries >= EPCTL_MAX_TRIES) begin
            // A zero cannot become one, or too many tries
            r_d.fail = 1'b1;
            r_d.st = EPCTL_ST_PDONE;
          end else begin
            r_d.oe_n = 1'b0;
            r_d.st = EPCTL_ST_PSETUP;
          end
        end
      end
      EPCTL_ST_PDONE: begin
        // Deselect before dropping supply
        r_d.sel_n = 1'b1;
        r_d.oe_n = 1'b1;
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt >= EPCTL_CNT_W'(EPCTL_SETUP_CYC)) begin
          r_d.pp_high = 1'b0;
          r_d.rvalid = 1'b1;
          r_d.st = EPCTL_ST_IDLE;
        end
      end
      default: begin
        r_d.st = EPCTL_ST_IDLE;
      end
    endcase
  end
  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      r_q <= '{st: EPCTL_ST_IDLE, cnt: '0, tries: 5'h00, over: 7'h00, addr: 13'h0000,
               wdata: 8'h00, ready: 1'b0, rvalid: 1'b0, rdata: 8'h00, fail: 1'b0,
               sel_n: 1'b1, gate_n: 1'b1, prog_n: 1'b1, pp_high: 1'b0, idv: 1'b0,
               oe_n: 1'b1};
    end else begin
      r_q <= r_d;
    end
  end
  // Outputs straight from flops
  assign cmd_ready = r_q.ready;
  assign rsp_valid = r_q.rvalid;
  assign rsp_rdata = r_q.rdata;
  assign rsp_fail = r_q.fail;
  assign addr_lines = r_q.addr;
  assign sel_n = r_q.sel_n;
  assign gate_n = r_q.gate_n;
  assign prog_n = r_q.prog_n;
  assign pp_high = r_q.pp_high;
  assign id_mode_voltage = r_q.idv;
  assign data_lines_o = r_q.wdata;
  assign data_lines_oe_n = r_q.oe_n;
endmodule : epctl_host

// *** hdl/epctl_pkg.sv ***
// Package with timing constants, states and commands of the EPROM controller
package epctl_pkg;
  // Array geometry
  localparam int EPCTL_ADDR_W = 13;
  localparam int EPCTL_DATA_W = 8;
  localparam logic [7:0] EPCTL_ERASED = 8'hff;
  // Clock period in picoseconds (250 MHz)
  localparam int EPCTL_CLK_PS = 4000;
  // Read timing in ns (slowest grade) and derived cycles, rounded up
  localparam int EPCTL_ADDR_ACC_NS = 450;
  localparam int EPCTL_GATE_ACC_NS = 150;
  localparam int EPCTL_FLOAT_NS = 130;
  localparam int EPCTL_ADDR_ACC_CYC = (EPCTL_ADDR_ACC_NS * 1000 + EPCTL_CLK_PS - 1) / EPCTL_CLK_PS;
  localparam int EPCTL_GATE_ACC_CYC = (EPCTL_GATE_ACC_NS * 1000 + EPCTL_CLK_PS - 1) / EPCTL_CLK_PS;
  localparam int EPCTL_FLOAT_CYC = (EPCTL_FLOAT_NS * 1000 + EPCTL_CLK_PS - 1) / EPCTL_CLK_PS;
  // Programming setup/hold in ns and cycles
  localparam int EPCTL_SETUP_NS = 2000;
  localparam int EPCTL_SETUP_CYC = (EPCTL_SETUP_NS * 1000 + EPCTL_CLK_PS - 1) / EPCTL_CLK_PS;
  // Initial program pulse in us (1 ms) as default for a top-level parameter
  localparam int EPCTL_PULSE_US = 1000;
  localparam int EPCTL_PULSE_CYC = (EPCTL_PULSE_US * 1000000 + EPCTL_CLK_PS - 1) / EPCTL_CLK_PS;
  // Most pulses tried on one byte before giving up
  localparam logic [4:0] EPCTL_MAX_TRIES = 5'h19;
  // Overprogram multiplier of pulse count
  localparam logic [1:0] EPCTL_OVER_MULT = 2'h3;
  // Wait counter width
  localparam int EPCTL_CNT_W = 20;
  // User command codes
  typedef enum logic [1:0] {
    EPCTL_CMD_READ = 2'b00,
    EPCTL_CMD_PROG = 2'b01,
    EPCTL_CMD_ID = 2'b10
  } epctl_cmd_e;
  // Sequencer states
  typedef enum logic [3:0] {
    EPCTL_ST_IDLE = 4'b0000,
    EPCTL_ST_RSEL = 4'b0001,
    EPCTL_ST_RGATE = 4'b0010,
    EPCTL_ST_RFLOAT = 4'b0011,
    EPCTL_ST_PSETUP = 4'b0100,
    EPCTL_ST_PPULSE = 4'b0101,
    EPCTL_ST_PHOLD = 4'b0110,
    EPCTL_ST_VGATE = 4'b0111,
    EPCTL_ST_VFLOAT = 4'b1000,
    EPCTL_ST_PDONE = 4'b1001
  } epctl_state_e;
endpackage : epctl_pkg

// *** hdl/epctl_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module epctl_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Asynchronous input and synchronised output
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q; // First stage, read only by second
  // Two flip-flops in series
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : epctl_sync

// *** testbench/epctl_host_assertions.sv ***
// Checker of the EPROM host pin sequencing
`timescale 1ns/1ps
module epctl_host_assertions (
  // Clock and reset
  input logic mclk,
  input logic rst,
  // Command side
  input logic cmd_valid,
  input logic cmd_ready,
  input logic rsp_valid,
  // Pins
  input logic [12:0] addr_lines,
  input logic sel_n,
  input logic gate_n,
  input logic prog_n,
  input logic pp_high,
  input logic id_mode_voltage,
  input logic data_lines_oe_n
);
  // Cycles spent with select low, saturating
  logic [9:0] sel_cnt_q;
  always_ff @(posedge mclk) begin
    if (rst || sel_n) begin
      sel_cnt_q <= 10'h000;
    end else if (sel_cnt_q != 10'h3ff) begin
      sel_cnt_q <= sel_cnt_q + 10'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Accepting a command selects the device
  sequence s_accept; cmd_valid && cmd_ready; endsequence
  sequence s_selected; !sel_n && !cmd_ready; endsequence
  a_accept_sel: assert property (s_accept |=> s_selected)
    else $error("select not lowered after accept");
  a_gate_wait: assert property ($fell(gate_n) |-> sel_cnt_q >= 10'h04b)
    else $error("gate lowered too soon");
  a_addr_stable: assert property (!gate_n |-> $stable(addr_lines) && !sel_n)
    else $error("address moved under gate");
  a_strobe_mode: assert property (!prog_n |-> gate_n && !sel_n && pp_high)
    else $error("strobe outside program mode");
  a_strobe_setup: assert property ($fell(prog_n) |-> sel_cnt_q >= 10'h1f4)
    else $error("strobe setup too short");
  a_no_fight: assert property (!gate_n || !prog_n |-> data_lines_oe_n == prog_n)
    else $error("data drive wrong");
  a_id_no_pp: assert property (id_mode_voltage |-> !pp_high && prog_n)
    else $error("id voltage with program supply");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && cmd_ready)
    else $error("response not single pulse");
endmodule : epctl_host_assertions
bind epctl_host epctl_host_assertions epctl_host_assertions_inst (.mclk(mclk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .addr_lines(addr_lines), .sel_n(sel_n), .gate_n(gate_n), .prog_n(prog_n),
  .pp_high(pp_high), .id_mode_voltage(id_mode_voltage), .data_lines_oe_n(data_lines_oe_n));

// *** testbench/epctl_dev_model.sv ***
// Behavioural model of the 8K x 8 UV EPROM
`timescale 1ns/1ps
module epctl_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary identity value
  parameter logic [7:0] PART_CODE = 8'h3c // Arbitrary identity value
) (
  // Pins from the host
  input logic [12:0] addr_lines,
  input logic sel_n,
  input logic gate_n,
  input logic prog_n,
  input logic pp_high,
  input logic id_mode_voltage,
  input logic [7:0] bus_in,
  // Bits that refuse to program
  input logic [7:0] stuck_mask,
  // Device data and its drive
  output logic [7:0] dev_q,
  output logic dev_drv
);
  logic [7:0] mem [0:8191]; // Byte array
  logic [7:0] last_q = 8'h00; // Last driven byte
  initial begin
    foreach (mem[i]) mem[i] = 8'hff; // Erased state
  end
  // Drive only with select and gate low, strobe high
  assign #100 dev_drv = !sel_n && !gate_n && prog_n;
  // Delay of 100 ns on select, gate and strobe only; address reaches data at once
  always @* begin
    if (dev_drv) begin
      dev_q = id_mode_voltage ? (addr_lines[0] ? PART_CODE : MAKER_CODE)
        : mem[addr_lines];
      last_q = dev_q;
    end else begin
      dev_q = ~last_q; // Released lines lose the value
    end
  end
  // Program pulse only clears bits
  always @(negedge prog_n) begin
    if (pp_high && !sel_n && gate_n) begin
      mem[addr_lines] = mem[addr_lines] & (bus_in | stuck_mask);
    end
  end
endmodule : epctl_dev_model

// *** testbench/tb_epctl_host.sv ***
// Self-checking bench of the EPROM host controller
`timescale 1ns/1ps
module tb_epctl_host;
  import epctl_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary identity value
  localparam logic [7:0] PART = 8'h3c; // Arbitrary identity value
  typedef struct {logic [1:0] op; logic [12:0] a; logic [7:0] w; logic [7:0] r; logic f;}
    epctl_row_s;
  logic mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_ready, rsp_valid, rsp_fail;
  logic [1:0] cmd_op = 2'h0;
  logic [12:0] cmd_addr = 13'h0000, addr_lines;
  logic [7:0] cmd_wdata = 8'h00, rsp_rdata, data_lines_o, dev_q, stuck = 8'h00, got_r;
  logic sel_n, gate_n, prog_n, pp_high, idv, oe_n, dev_drv, got_f;
  wire [7:0] dq = !oe_n ? data_lines_o : dev_q;
  int err_total = 0;
  int check_count = 0;
  epctl_row_s rows [7] = '{'{2'h0, 13'h0000, 8'h00, 8'hff, 1'b0},
    '{2'h1, 13'h1fff, 8'ha5, 8'ha5, 1'b0}, '{2'h0, 13'h1fff, 8'h00, 8'ha5, 1'b0},
    '{2'h1, 13'h1fff, 8'h0f, 8'h05, 1'b1}, '{2'h0, 13'h1fff, 8'h00, 8'h05, 1'b0},
    '{2'h2, 13'h0000, 8'h00, MAKER, 1'b0}, '{2'h2, 13'h0001, 8'h00, PART, 1'b0}};
  always #2 mclk = ~mclk;
  epctl_host #(.PULSE_CYC(20)) epctl_host_inst (.mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_fail(rsp_fail),
    .addr_lines(addr_lines), .sel_n(sel_n), .gate_n(gate_n), .prog_n(prog_n),
    .pp_high(pp_high), .id_mode_voltage(idv), .data_lines_o(data_lines_o),
    .data_lines_oe_n(oe_n), .data_lines_i(dq));
  epctl_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) epctl_dev_model_inst (
    .addr_lines(addr_lines), .sel_n(sel_n), .gate_n(gate_n), .prog_n(prog_n),
    .pp_high(pp_high), .id_mode_voltage(idv), .bus_in(dq), .stuck_mask(stuck),
    .dev_q(dev_q), .dev_drv(dev_drv));
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // Issue one command and wait for its response
  task automatic run(input logic [1:0] op, input logic [12:0] a, input logic [7:0] w);
    int n;
    n = 0;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= w;
    cmd_valid <= 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 60000);
    // A command that never answers counts as a mismatch
    if (rsp_valid !== 1'b1) begin
      err_total++;
    end
    got_r = rsp_rdata;
    got_f = rsp_fail;
  endtask : run
  // Verdict and end of run
  task automatic finish_test;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog
  initial begin
    repeat (80000) @(posedge mclk);
    err_total++;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check({sel_n, prog_n, gate_n, pp_high, idv, oe_n, 2'h0}, 8'he4);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].w);
      check({7'h00, got_f}, {7'h00, rows[i].f});
      check(got_r, rows[i].r);
    end
    stuck <= 8'h01;
    run(2'h1, 13'h0002, 8'hfe);
    check({7'h00, got_f}, 8'h01);
    check(got_r, 8'hff);
    stuck <= 8'h00;
    run(2'h0, 13'h0002, 8'h00);
    check(got_r, 8'hff);
    // Reset in the middle of a read parks every pin
    cmd_op <= 2'h0;
    cmd_addr <= 13'h1fff;
    cmd_valid <= 1'b1;
    repeat (90) @(posedge mclk);
    cmd_valid <= 1'b0;
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check({sel_n, prog_n, gate_n, pp_high, idv, oe_n, 2'h0}, 8'he4);
    // A read after that reset still works
    run(2'h0, 13'h1fff, 8'h00);
    check({7'h00, got_f}, 8'h00);
    check(got_r, 8'h05);
    finish_test;
  end
endmodule : tb_epctl_host
